// file: core/jcl_host.sv
// Boundary-scan configuration loader host with AXI4-Lite command registers
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/10ps
module jcl_host (
    input wire logic clock,
    input wire logic rst,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic jtag_tck,
    output logic jtag_tms,
    output logic jtag_tdi,
    input wire logic jtag_tdo,
    output logic cfg_program_n,
    input wire logic cfg_done
);
    import jcl_pkg::*;

    // Pin synchronisers
    logic [1:0] pins_sync;
    logic tdo_s;
    logic done_s;
    jcl_sync #(.WIDTH(2)) u_sync (
        .clock(clock),
        .rst(rst),
        .async_in({cfg_done, jtag_tdo}),
        .sync_out(pins_sync)
    );
    assign tdo_s = pins_sync[0];
    assign done_s = pins_sync[1];

    // AXI4-Lite slave
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic aw_got_q, w_got_q;
    logic [4:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;

    logic aw_take, w_take, do_write, ar_take;
    logic aw_got_d, w_got_d, bvalid_d, rvalid_d;
    assign aw_take = s_axi_awvalid & awready_q;
    assign w_take = s_axi_wvalid & wready_q;
    assign do_write = aw_got_q & w_got_q;
    assign aw_got_d = (aw_got_q | aw_take) & ~do_write;
    assign w_got_d = (w_got_q | w_take) & ~do_write;
    assign bvalid_d = do_write | (bvalid_q & ~s_axi_bready);
    assign ar_take = s_axi_arvalid & arready_q;
    assign rvalid_d = ar_take | (rvalid_q & ~s_axi_rready);

    logic [31:0] wmask;
    assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

    logic wr_ctrl, wr_ir, wr_len, wr_data, wr_count, wr_status, wr_known;
    assign wr_ctrl = do_write & (awaddr_q == ADDR_CTRL);
    assign wr_ir = do_write & (awaddr_q == ADDR_IR_VALUE);
    assign wr_len = do_write & (awaddr_q == ADDR_IR_LENGTH);
    assign wr_data = do_write & (awaddr_q == ADDR_DR_DATA);
    assign wr_count = do_write & (awaddr_q == ADDR_COUNT);
    assign wr_status = do_write & (awaddr_q == ADDR_STATUS);
    assign wr_known = wr_ctrl | wr_ir | wr_len | wr_data | wr_count | wr_status;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else begin
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            awready_q <= ~aw_got_d & ~bvalid_d;
            wready_q <= ~w_got_d & ~bvalid_d;
            bvalid_q <= bvalid_d;
            if (do_write) begin
                bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            awaddr_q <= 5'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (aw_take) begin
                awaddr_q <= {s_axi_awaddr[4:2], 2'h0};
            end
            if (w_take) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
        end
    end

    // Software registers
    logic [31:0] ir_value_q, dr_data_q, ctrl_q;
    logic [5:0] ir_len_q;
    logic [15:0] count_q;
    logic refused_q;
    jcl_state_type state_q;

    logic [31:0] ctrl_new;
    logic [3:0] cmd;
    logic cmd_last, cmd_known, accept;
    assign ctrl_new = (ctrl_q & ~wmask) | (wdata_q & wmask);
    assign cmd = ctrl_new[3:0];
    assign cmd_last = ctrl_new[CTRL_LAST_BIT];
    assign cmd_known = (cmd >= CMD_RESET) & (cmd <= CMD_PROGRAM);
    // One operation at a time; chained devices are handled by successive commands
    assign accept = wr_ctrl & cmd_known & (state_q == S_IDLE);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_q <= 32'h0000_0000;
            ir_value_q <= IR_CONFIG_LOAD;
            ir_len_q <= IR_LEN_RESET;
            dr_data_q <= 32'h0000_0000;
            count_q <= STARTUP_MIN;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= ctrl_new;
            end
            if (wr_ir) begin
                ir_value_q <= (ir_value_q & ~wmask) | (wdata_q & wmask);
            end
            if (wr_len) begin
                ir_len_q <= (ir_len_q & wmask[5:0]) ^ ir_len_q ^ (wdata_q[5:0] & wmask[5:0]);
            end
            if (wr_data) begin
                dr_data_q <= (dr_data_q & ~wmask) | (wdata_q & wmask);
            end
            if (wr_count) begin
                count_q <= (count_q & ~wmask[15:0]) | (wdata_q[15:0] & wmask[15:0]);
            end
        end
    end

    // Refused command flag: a new refusal wins over a clear in the same cycle
    logic refuse_evt;
    assign refuse_evt = wr_ctrl & ~accept;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            refused_q <= 1'b0;
        end else if (refuse_evt) begin
            refused_q <= 1'b1;
        end else if (wr_status & wstrb_q[0] & wdata_q[STAT_REFUSED_BIT]) begin
            refused_q <= 1'b0;
        end
    end

    // Read path
    logic [31:0] capture_q;
    logic program_n_q;
    logic [31:0] status_word;
    logic [31:0] rd_mux;
    logic rd_known;
    assign status_word = {28'h000_0000, ~program_n_q, refused_q, done_s, (state_q != S_IDLE)};
    assign rd_known = (s_axi_araddr[4:2] <= ADDR_CAPTURE[4:2]);
    assign rd_mux = (s_axi_araddr[4:2] == ADDR_CTRL[4:2]) ? ctrl_q :
                    (s_axi_araddr[4:2] == ADDR_IR_VALUE[4:2]) ? ir_value_q :
                    (s_axi_araddr[4:2] == ADDR_IR_LENGTH[4:2]) ? {26'h000_0000, ir_len_q} :
                    (s_axi_araddr[4:2] == ADDR_DR_DATA[4:2]) ? dr_data_q :
                    (s_axi_araddr[4:2] == ADDR_COUNT[4:2]) ? {16'h0000, count_q} :
                    (s_axi_araddr[4:2] == ADDR_STATUS[4:2]) ? status_word :
                    (s_axi_araddr[4:2] == ADDR_CAPTURE[4:2]) ? capture_q :
                    32'h0000_0000;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else begin
            arready_q <= ~rvalid_d;
            rvalid_q <= rvalid_d;
            if (ar_take) begin
                rdata_q <= rd_mux;
                rresp_q <= rd_known ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // Per-command load values for the bit sequencer
    logic [7:0] ld_pre_pat, ld_post_pat;
    logic [2:0] ld_pre_len, ld_post_len;
    logic [15:0] ld_sh_len, start_cnt;
    logic [31:0] ld_sh_data;
    logic ld_msb, ld_last_hi;
    logic [5:0] pad_cnt;
    logic is_reset, is_ir, is_dr, is_pad, is_start, is_idle;
    assign is_reset = (cmd == CMD_RESET);
    assign is_ir = (cmd == CMD_IR);
    assign is_dr = (cmd == CMD_DR_WORD);
    assign is_pad = (cmd == CMD_PAD);
    assign is_start = (cmd == CMD_STARTUP);
    assign is_idle = (cmd == CMD_IDLE);
    assign pad_cnt = PAD_BASE - {1'b0, count_q[4:0]};
    assign start_cnt = (count_q < STARTUP_MIN) ? STARTUP_MIN : count_q;

    assign ld_pre_pat = is_reset ? PAT_RESET : is_ir ? PAT_TO_SHIFT : PAT_IDLE;
    assign ld_pre_len = is_reset ? LEN_RESET : is_ir ? LEN_TO_SHIFT : is_idle ? LEN_IDLE : 3'h0;
    assign ld_sh_len = is_ir ? {10'h000, ir_len_q} : is_dr ? DR_WORD_BITS :
                       is_pad ? {10'h000, pad_cnt} : is_start ? start_cnt : 16'h0000;
    // Instruction shifts LSB first; bypass patterns for chained devices come from software
    assign ld_sh_data = is_ir ? ir_value_q : is_dr ? dr_data_q : 32'h0000_0000;
    assign ld_msb = is_dr;
    assign ld_last_hi = is_ir | (is_dr & cmd_last);
    assign ld_post_pat = is_ir ? PAT_TO_SHIFT : is_dr ? PAT_UPDATE : PAT_TO_IDLE;
    assign ld_post_len = is_ir ? LEN_TO_SHIFT : (is_dr & cmd_last) ? LEN_UPDATE :
                         is_start ? LEN_TO_IDLE : 3'h0;

    // Bit sequencer: pre pattern, data bits, post pattern
    logic [7:0] pre_pat_q, post_pat_q;
    logic [2:0] pre_left_q, post_left_q;
    logic [15:0] sh_left_q;
    logic [31:0] sh_data_q;
    logic msb_q, last_hi_q;
    logic in_pre, in_sh, in_post, bit_avail, bit_tms, bit_tdi;
    assign in_pre = (pre_left_q != 3'h0);
    assign in_sh = ~in_pre & (sh_left_q != 16'h0000);
    assign in_post = ~in_pre & ~in_sh & (post_left_q != 3'h0);
    assign bit_avail = in_pre | in_sh | in_post;
    assign bit_tms = in_pre ? pre_pat_q[0] :
                     in_sh ? (last_hi_q & (sh_left_q == 16'h0001)) : post_pat_q[0];
    assign bit_tdi = in_sh & (msb_q ? sh_data_q[31] : sh_data_q[0]);

    // Test clock divider and edge timing
    logic [3:0] div_q;
    logic tck_q, tms_q, tdi_q, pend_q, pend_sh_q;
    logic tick, fetch, rise;
    assign tick = (state_q == S_RUN) & (div_q == TCK_HALF_CYC - 4'h1);
    assign fetch = tick & (tck_q | ~pend_q);
    assign rise = tick & ~tck_q & pend_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pre_pat_q <= 8'h00;
            pre_left_q <= 3'h0;
            post_pat_q <= 8'h00;
            post_left_q <= 3'h0;
        end else if (accept) begin
            pre_pat_q <= ld_pre_pat;
            pre_left_q <= ld_pre_len;
            post_pat_q <= ld_post_pat;
            post_left_q <= ld_post_len;
        end else if (fetch & in_pre) begin
            pre_pat_q <= {1'b0, pre_pat_q[7:1]};
            pre_left_q <= pre_left_q - 3'h1;
        end else if (fetch & in_post) begin
            post_pat_q <= {1'b0, post_pat_q[7:1]};
            post_left_q <= post_left_q - 3'h1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sh_left_q <= 16'h0000;
            sh_data_q <= 32'h0000_0000;
            msb_q <= 1'b0;
            last_hi_q <= 1'b0;
        end else if (accept) begin
            sh_left_q <= ld_sh_len;
            sh_data_q <= ld_sh_data;
            msb_q <= ld_msb;
            last_hi_q <= ld_last_hi;
        end else if (fetch & in_sh) begin
            sh_left_q <= sh_left_q - 16'h0001;
            sh_data_q <= msb_q ? {sh_data_q[30:0], 1'b0} : {1'b0, sh_data_q[31:1]};
        end
    end

    // Pins change at the falling edge, or with the clock still low for a command's first bit, so the device samples stable levels on the rise
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            div_q <= 4'h0;
            tck_q <= 1'b0;
            tms_q <= 1'b1;
            tdi_q <= 1'b0;
            pend_q <= 1'b0;
            pend_sh_q <= 1'b0;
        end else begin
            div_q <= (tick | (state_q != S_RUN)) ? 4'h0 : div_q + 4'h1;
            if (tick) begin
                tck_q <= ~tck_q & pend_q;
            end
            if (fetch) begin
                pend_q <= bit_avail;
                pend_sh_q <= in_sh;
                if (bit_avail) begin
                    tms_q <= bit_tms;
                    tdi_q <= bit_tdi;
                end
            end
        end
    end

    // Data captured from the device on each rising test clock of a data bit
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            capture_q <= 32'h0000_0000;
        end else if (rise & pend_sh_q) begin
            capture_q <= msb_q ? {capture_q[30:0], tdo_s} : {tdo_s, capture_q[31:1]};
        end
    end

    // Operation state and restart pulse
    logic [6:0] pulse_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= S_IDLE;
            pulse_q <= 7'h00;
            program_n_q <= 1'b1;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (accept & (cmd == CMD_PROGRAM)) begin
                        state_q <= S_PULSE;
                        pulse_q <= PROG_PULSE_CYC;
                        program_n_q <= 1'b0;
                    end else if (accept) begin
                        state_q <= S_RUN;
                    end
                end
                S_RUN: begin
                    if (fetch & ~bit_avail) begin
                        state_q <= S_IDLE;
                    end
                end
                S_PULSE: begin
                    pulse_q <= pulse_q - 7'h01;
                    if (pulse_q == 7'h01) begin
                        program_n_q <= 1'b1;
                        state_q <= S_IDLE;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                    program_n_q <= 1'b1;
                end
            endcase
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign jtag_tck = tck_q;
    assign jtag_tms = tms_q;
    assign jtag_tdi = tdi_q;
    assign cfg_program_n = program_n_q;
endmodule

// file: core/jcl_pkg.sv
// Constants, register map and command codes of the configuration loader host
package jcl_pkg;

    localparam int CLK_PERIOD_NS = 4;
    localparam int TCK_HALF_NS = 24;
    localparam int TCK_HALF_CYC_I = (TCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] TCK_HALF_CYC = 4'(TCK_HALF_CYC_I);
    localparam int PROG_PULSE_NS = 300;
    localparam int PROG_PULSE_CYC_I = (PROG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [6:0] PROG_PULSE_CYC = 7'(PROG_PULSE_CYC_I);

    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_IR_VALUE = 5'h04;
    localparam logic [4:0] ADDR_IR_LENGTH = 5'h08;
    localparam logic [4:0] ADDR_DR_DATA = 5'h0C;
    localparam logic [4:0] ADDR_COUNT = 5'h10;
    localparam logic [4:0] ADDR_STATUS = 5'h14;
    localparam logic [4:0] ADDR_CAPTURE = 5'h18;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [3:0] CMD_RESET = 4'h1;
    localparam logic [3:0] CMD_IR = 4'h2;
    localparam logic [3:0] CMD_DR_WORD = 4'h3;
    localparam logic [3:0] CMD_PAD = 4'h4;
    localparam logic [3:0] CMD_STARTUP = 4'h5;
    localparam logic [3:0] CMD_IDLE = 4'h6;
    localparam logic [3:0] CMD_PROGRAM = 4'h7;
    localparam int CTRL_LAST_BIT = 8;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_REFUSED_BIT = 2;
    localparam int STAT_PROG_BIT = 3;

    localparam logic [31:0] IR_CONFIG_LOAD = 32'h0000_0005;
    localparam logic [31:0] IR_STARTUP_CLOCK = 32'h0000_000C;
    localparam logic [31:0] IR_BYPASS = 32'hFFFF_FFFF;
    localparam logic [5:0] IR_LEN_RESET = 6'h05;
    localparam logic [15:0] STARTUP_MIN = 16'h000C;
    localparam logic [5:0] PAD_BASE = 6'h20;
    localparam logic [15:0] DR_WORD_BITS = 16'h0020;

    // TMS patterns, sent from bit 0 upward
    localparam logic [7:0] PAT_RESET = 8'h1F;
    localparam logic [2:0] LEN_RESET = 3'h6;
    localparam logic [7:0] PAT_TO_SHIFT = 8'h03;
    localparam logic [2:0] LEN_TO_SHIFT = 3'h4;
    localparam logic [7:0] PAT_UPDATE = 8'h01;
    localparam logic [2:0] LEN_UPDATE = 3'h1;
    localparam logic [7:0] PAT_TO_IDLE = 8'h03;
    localparam logic [2:0] LEN_TO_IDLE = 3'h3;
    localparam logic [7:0] PAT_IDLE = 8'h00;
    localparam logic [2:0] LEN_IDLE = 3'h1;

    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_RUN = 3'b010,
        S_PULSE = 3'b100
    } jcl_state_type;

endpackage

// file: core/jcl_sync.sv
// Two-flop synchroniser bank for pins arriving from outside the clock domain
`timescale 1ns/10ps
module jcl_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_q;
            logic sync_q;
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= async_in[i];
                    sync_q <= meta_q;
                end
            end
            assign sync_out[i] = sync_q;
        end
    endgenerate
endmodule

// file: dv/jcl_dev_model.sv
// Behavioural model of the configurable device behind the test access port
`timescale 1ns/10ps
module jcl_dev_model (
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic program_n,
    output logic tdo,
    output logic done
);
    // Next-state tables of the port controller, four bits per state
    localparam logic [63:0] NXT_LO = 64'h1BDD_BBA1_4664_4311;
    localparam logic [63:0] NXT_HI = 64'h2FEF_CC02_8785_5920;
    logic [3:0] st_q = 4'h0;
    logic [4:0] ir_sh_q = 5'h00;
    logic [4:0] ir_q = 5'h00;
    logic [31:0] dr_q = 32'h0000_0000;
    logic [15:0] nbits_q = 16'h0000;
    logic [15:0] start_q = 16'h0000;
    logic loaded_q = 1'b0;
    wire [3:0] st_d = tms ? NXT_HI[{st_q, 2'b00} +: 4] : NXT_LO[{st_q, 2'b00} +: 4];
    initial done = 1'b0;
    initial tdo = 1'b0;
    // A restart clears the loaded configuration, the startup count and done
    always @(posedge tck or negedge program_n) begin
        if (!program_n) begin
            st_q <= 4'h0;
            start_q <= 16'h0000;
            loaded_q <= 1'b0;
            done <= 1'b0;
        end else begin
            st_q <= st_d;
            if (st_q == 4'hB) ir_sh_q <= {tdi, ir_sh_q[4:1]};
            if (st_q == 4'hF) ir_q <= ir_sh_q;
            if (st_q == 4'h4) begin
                dr_q <= {dr_q[30:0], tdi};
                nbits_q <= nbits_q + 16'h0001;
            end
            if (st_q == 4'h4 && ir_q == 5'h05) loaded_q <= 1'b1;
            if (st_q == 4'h4 && ir_q == 5'h0C) start_q <= start_q + 16'h0001;
            if (start_q >= 16'h000C && loaded_q) done <= 1'b1;
        end
    end
    // Released line shows a toggling pattern
    always @(negedge tck) begin
        tdo <= (st_q == 4'h4) ? dr_q[31] : (st_q == 4'hB) ? ir_sh_q[0] : ~tdo;
    end
endmodule

// file: dv/jcl_host_monitor.sv
// Port checker for the configuration loader host
`timescale 1ns/10ps
module jcl_host_monitor (
    input wire logic clock,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic jtag_tck,
    input wire logic jtag_tms,
    input wire logic jtag_tdi,
    input wire logic cfg_program_n
);
    logic [7:0] low_cnt_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) low_cnt_q <= 8'h00;
        else if (!cfg_program_n) low_cnt_q <= low_cnt_q + 8'h01;
        else low_cnt_q <= 8'h00;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_tck_high_six: assert property ($rose(jtag_tck) |-> jtag_tck [*6] ##1 !jtag_tck)
        else $error("test clock high phase wrong");
    a_tck_low_six: assert property ($fell(jtag_tck) |-> !jtag_tck [*6])
        else $error("test clock low phase too short");
    a_tms_steady: assert property (jtag_tck |-> $stable(jtag_tms) && $stable(jtag_tdi))
        else $error("mode select or data moved while clock high");
    a_restart_width: assert property ($rose(cfg_program_n) |-> low_cnt_q == 8'h4B)
        else $error("restart pulse width wrong");
    a_aw_drop: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("write address ready stayed high");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response timing wrong");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
        $stable(s_axi_bresp))
        else $error("write response not held");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid &&
        !s_axi_arready)
        else $error("read response timing wrong");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
        $stable(s_axi_rdata))
        else $error("read data not held");
endmodule
bind jcl_host jcl_host_monitor mon (.clock(clock), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .jtag_tck(jtag_tck),
    .jtag_tms(jtag_tms), .jtag_tdi(jtag_tdi), .cfg_program_n(cfg_program_n));

// file: dv/tb_top.sv
// Self-checking bench of the configuration loader host
`timescale 1ns/10ps
module tb_top;
    import jcl_pkg::*;
    typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} jcl_exp_type;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [4:0] awaddr = 5'h00, araddr = 5'h00, pos;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000, seed = 32'h0001_6F82, rd_val;
    logic [15:0] nb0;
    wire awready, wready, bvalid, arready, rvalid, tck, tms, tdi, tdo, prog_n, done;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    int n_fail = 0, total_checks = 0;
    jcl_exp_type rq[$], bq[$];
    jcl_host DUT (.clock(clock), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .jtag_tck(tck), .jtag_tms(tms), .jtag_tdi(tdi), .jtag_tdo(tdo), .cfg_program_n(prog_n),
        .cfg_done(done));
    jcl_dev_model dev (.tck(tck), .tms(tms), .tdi(tdi), .program_n(prog_n), .tdo(tdo),
        .done(done));
    initial forever #2 clock = ~clock;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task give_verdict;
        $display("COUNTS fail=%0d checks=%0d", n_fail, total_checks);
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task bad(input string s);
        n_fail++;
        $display("BAD %0t %s", $time, s);
    endtask
    task fail_out(input string s);
        bad(s);
        give_verdict;
    endtask
    task cmp_read(input jcl_exp_type e);
        total_checks++;
        if (((rdata & e.m) !== (e.d & e.m)) || (rresp !== e.r)) bad("read mismatch");
    endtask
    task cmp_resp(input jcl_exp_type e);
        total_checks++;
        if (bresp !== e.r) bad("write response mismatch");
    endtask
    task cmp_val(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) bad("device state mismatch");
    endtask
    always @(posedge clock) begin
        if (rvalid && rready && rq.size() > 0) cmp_read(rq.pop_front());
        if (bvalid && bready && bq.size() > 0) cmp_resp(bq.pop_front());
    end
    task axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
        int i;
        bq.push_back('{d, 32'h0000_0000, r});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (i == 100) fail_out("write timeout");
        @(posedge clock);
    endtask
    task axi_rd(input logic [4:0] a, input logic [31:0] d, input logic [31:0] m,
        input logic [1:0] r);
        int i;
        rq.push_back('{d, m, r});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                rd_val = rdata;
                break;
            end
        end
        rready <= 1'b0;
        if (i == 100) fail_out("read timeout");
        @(posedge clock);
    endtask
    task run(input logic [31:0] w);
        int i;
        axi_wr(ADDR_CTRL, w, RESP_OKAY);
        for (i = 0; i < 300; i++) begin
            axi_rd(ADDR_STATUS, 32'h0000_0000, 32'h0000_0000, RESP_OKAY);
            if (rd_val[STAT_BUSY_BIT] === 1'b0) break;
        end
        if (i == 300) fail_out("busy timeout");
    endtask
    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        axi_rd(ADDR_IR_VALUE, IR_CONFIG_LOAD, 32'hFFFF_FFFF, RESP_OKAY);
        axi_rd(ADDR_IR_LENGTH, 32'h0000_0005, 32'h0000_003F, RESP_OKAY);
        axi_rd(ADDR_COUNT, 32'h0000_000C, 32'h0000_FFFF, RESP_OKAY);
        axi_rd(ADDR_STATUS, 32'h0000_0000, 32'h0000_000F, RESP_OKAY);
        axi_rd(5'h1C, 32'h0000_0000, 32'hFFFF_FFFF, RESP_SLVERR);
        axi_wr(5'h1C, 32'hA5A5_A5A5, RESP_SLVERR);
        $display("TEST registers done");
        run(32'(CMD_RESET));
        cmp_val(32'(dev.st_q), 32'h0000_0001);
        run(32'(CMD_IR));
        cmp_val(32'(dev.ir_q), IR_CONFIG_LOAD);
        cmp_val(32'(dev.st_q), 32'h0000_0004);
        seed = xs(seed);
        axi_wr(ADDR_DR_DATA, seed, RESP_OKAY);
        run(32'(CMD_DR_WORD));
        run(32'h0000_0100 | 32'(CMD_DR_WORD));
        cmp_val(dev.dr_q, seed);
        cmp_val(32'(dev.st_q), 32'h0000_0008);
        axi_rd(ADDR_CAPTURE, seed, 32'hFFFF_FFFF, RESP_OKAY);
        axi_wr(ADDR_IR_VALUE, IR_STARTUP_CLOCK, RESP_OKAY);
        run(32'(CMD_IR));
        cmp_val(32'(dev.ir_q), IR_STARTUP_CLOCK);
        run(32'(CMD_STARTUP));
        cmp_val(32'(dev.st_q), 32'h0000_0001);
        axi_rd(ADDR_STATUS, 32'h0000_0002, 32'h0000_0007, RESP_OKAY);
        $display("TEST single load done");
        axi_wr(ADDR_CTRL, 32'(CMD_IDLE), RESP_OKAY);
        run(32'(CMD_IDLE));
        axi_rd(ADDR_STATUS, 32'h0000_0006, 32'h0000_0007, RESP_OKAY);
        axi_wr(ADDR_STATUS, 32'h0000_0004, RESP_OKAY);
        axi_rd(ADDR_STATUS, 32'h0000_0002, 32'h0000_0007, RESP_OKAY);
        $display("TEST refusal done");
        seed = xs(seed);
        pos = seed[4:0];
        axi_wr(ADDR_COUNT, 32'(pos), RESP_OKAY);
        axi_wr(ADDR_IR_VALUE, IR_CONFIG_LOAD, RESP_OKAY);
        run(32'(CMD_IR));
        nb0 = dev.nbits_q;
        run(32'(CMD_PAD));
        cmp_val(32'(dev.nbits_q - nb0), 32'h0000_0020 - 32'(pos));
        $display("TEST padding done");
        run(32'(CMD_PROGRAM));
        cmp_val(32'(dev.st_q), 32'h0000_0000);
        axi_rd(ADDR_STATUS, 32'h0000_0000, 32'h0000_000B, RESP_OKAY);
        $display("TEST restart done");
        give_verdict;
    end
    initial begin
        #400000;
        fail_out("run timeout");
    end
endmodule
